// *** hw/psp_regs.svh ***
/*
  Register offsets, field positions, reset values and timing counts for the
  programmable supply parallel port controller.
  Assumes a 25 MHz pclk and a 12-bit APB byte address.
*/
// Summary of operation
// (R01) All programming lines are inverted: asserted bit is a low level.
// (R02) Low range: 14 magnitude lines are straight binary, one millivolt per count.
// (R03) High range: device scales magnitude by four, four millivolts per count.
// (R04) Range line deasserted selects 16 V, asserted selects 65 V.
// (R05) Standby line deasserted operates, asserted enters standby.
// (R06) Sign line deasserted gives positive output, asserted negative.
// (R07) Reference select deasserted uses internal reference, asserted external.
// (R08) Device shows settle flag deasserted when ready, asserted when not.
// (R09) Current range deasserted selects 100 mA, asserted 1 A.
// (R10) Four limit lines weigh 80, 40, 20, 10 percent; all clear gives 10.
// (R11) Device asserts overload flag while a current overload exists.
// (R12) Latched variant: negative values use two's complement; signed zero invalid.
// (R13) Latched variant: device captures inputs on strobe falling edge.
// (R14) Strobe fall starts 15 us hold of previous output setting.
// (R15) Strobe fall raises not-ready for 100 us while output settles.
// (R16) Data lines stay stable at least 24 us after strobe falling edge.
// (R17) After power-up device outputs zero volts until a new transfer.
// (R18) Direct variant: strobe active freezes output, else output follows inputs.
// (R19) Direct variant: strobe stays active while the inputs are changed.
// (R20) Direct variant: 100 us not-ready starts when strobe release ends.
// (R21) Overload raises both flags; not-ready lingers 100 us after clearing.
// (R22) Current limiting also raises the overload flag.
// (R23) Device times hold and settle with counters restarted per strobe edge.
// (R24) Device synchronises strobe and inputs before detecting edges.
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH

// ==========================================================
// Register offsets
`define PSP_ADDR_W 12
`define PSP_OFF_CTRL 12'h000
`define PSP_OFF_DATA 12'h004
`define PSP_OFF_STAT 12'h008

// ==========================================================
// Control fields
`define PSP_CTRL_GO 0
`define PSP_CTRL_DIRECT 1

// ==========================================================
// Data fields
`define PSP_MAG_W 14
`define PSP_DATA_MAG_LSB 0
`define PSP_DATA_SIGN 14
`define PSP_DATA_RANGE 15
`define PSP_DATA_STANDBY 16
`define PSP_DATA_EXTREF 17
`define PSP_DATA_IRANGE 18
`define PSP_DATA_ILIM_LSB 19
`define PSP_ILIM_W 4
`define PSP_DATA_W 23
`define PSP_DATA_RST 23'h000000
`define PSP_MAG_ZERO 14'h0000
`define PSP_MAG_ONE 14'h0001

// ==========================================================
// Status fields
`define PSP_STAT_BUSY 0
`define PSP_STAT_NRDY 1
`define PSP_STAT_OVLD 2
`define PSP_STAT_ERR 3

// ==========================================================
// Timing
`define PSP_CLK_MHZ 25
`define PSP_HOLD_US 24
`define PSP_SETUP_NS 200
`define PSP_TMR_W 10
`define PSP_HOLD_CYC (`PSP_HOLD_US * `PSP_CLK_MHZ)
`define PSP_SETUP_CYC ((`PSP_SETUP_NS * `PSP_CLK_MHZ + 999) / 1000)

`endif

// *** hw/psp_pkg.sv ***
/*
  Types for the programmable supply parallel port controller.
  Assumes nothing beyond the constant header.
*/
package psp_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_drive,
    st_strb,
    st_freeze,
    st_change
  } psp_state_e;
endpackage

// *** hw/psp_timer.sv ***
/*
  Down counter that pulses expired a fixed time after load.
  Assumes load is a single-cycle pulse in the pclk domain.
*/
`timescale 1ns/1ps
`include "psp_regs.svh"

module psp_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [`PSP_TMR_W-1:0] count,
  output logic expired
);
  logic [`PSP_TMR_W-1:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // Fires once as the count reaches its end, never while idle at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expired <= 1'b0;
    end else begin
      expired <= !load && (cnt_reg == {{(`PSP_TMR_W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// *** hw/psp_ctrl.sv ***
/*
  Host controller that programs the supply through its parallel port.
  Software sets the word over APB; the controller drives the inverted pins
  and the strobe in latched or direct-coupled style and reports the flags.
  Assumes the flag inputs are already synchronous to pclk.
*/
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "psp_regs.svh"

module psp_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PSP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [`PSP_MAG_W-1:0] mag_n,
  output logic sign_n,
  output logic range_n,
  output logic standby_n,
  output logic extref_n,
  output logic irange_n,
  output logic [`PSP_ILIM_W-1:0] ilim_n,
  output logic strobe_n,
  input wire logic not_ready_n,
  input wire logic overload_n
);
  // ==========================================================
  // Registers and decode
  psp_pkg::psp_state_e state_reg;
  logic direct_reg;
  logic [`PSP_DATA_W-1:0] data_reg;
  logic err_reg;
  logic nrdy_reg;
  logic ovld_reg;
  logic wr_en;
  logic go;
  logic [`PSP_MAG_W-1:0] mag;
  logic sign;
  logic bad_word;
  logic go_ok;
  logic load_pins;
  logic tmr_load;
  logic [`PSP_TMR_W-1:0] tmr_count;
  logic tmr_expired;
  logic [`PSP_MAG_W-1:0] mag_out;
  logic busy;

  assign wr_en = psel && penable && pwrite && pready;
  assign go = wr_en && (paddr == `PSP_OFF_CTRL) && pwdata[`PSP_CTRL_GO];
  assign mag = data_reg[`PSP_DATA_MAG_LSB +: `PSP_MAG_W];
  assign sign = data_reg[`PSP_DATA_SIGN];
  // Signed zero has no two's complement meaning on the latched port
  assign bad_word = !direct_reg && sign && (mag == `PSP_MAG_ZERO); // R12
  assign go_ok = go && (state_reg == psp_pkg::st_idle) && !bad_word;
  assign busy = (state_reg != psp_pkg::st_idle);
  assign mag_out = (!direct_reg && sign) ? (~mag + `PSP_MAG_ONE) : mag; // R12

  always_comb begin
    load_pins = 1'b0;
    tmr_load = 1'b0;
    tmr_count = `PSP_TMR_W'(`PSP_SETUP_CYC);
    case (state_reg)
      psp_pkg::st_idle: begin
        load_pins = go_ok && !direct_reg;
        tmr_load = go_ok;
      end
      psp_pkg::st_drive: begin
        tmr_load = tmr_expired;
        tmr_count = `PSP_TMR_W'(`PSP_HOLD_CYC); // R16
      end
      psp_pkg::st_freeze: begin
        load_pins = tmr_expired; // R19
        tmr_load = tmr_expired;
      end
      default: begin
        load_pins = 1'b0;
      end
    endcase
  end

  psp_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_expired)
  );

  // ==========================================================
  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_reg <= 1'b0;
      data_reg <= `PSP_DATA_RST;
    end else if (wr_en) begin
      if (paddr == `PSP_OFF_CTRL) begin
        direct_reg <= pwdata[`PSP_CTRL_DIRECT];
      end
      if (paddr == `PSP_OFF_DATA) begin
        data_reg <= pwdata[`PSP_DATA_W-1:0];
      end
    end
  end

  // Rejected start sets the error; a new rejection beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else if (go && !busy && bad_word) begin
      err_reg <= 1'b1;
    end else if (wr_en && (paddr == `PSP_OFF_STAT) && pwdata[`PSP_STAT_ERR]) begin
      err_reg <= 1'b0;
    end
  end

  // Flags arrive active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nrdy_reg <= 1'b0;
      ovld_reg <= 1'b0;
    end else begin
      nrdy_reg <= !not_ready_n; // R01
      ovld_reg <= !overload_n; // R01
    end
  end

  // Zero wait: data is registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `PSP_OFF_CTRL: prdata[`PSP_CTRL_DIRECT] <= direct_reg;
          `PSP_OFF_DATA: prdata[`PSP_DATA_W-1:0] <= data_reg;
          `PSP_OFF_STAT: begin
            prdata[`PSP_STAT_BUSY] <= busy;
            prdata[`PSP_STAT_NRDY] <= nrdy_reg;
            prdata[`PSP_STAT_OVLD] <= ovld_reg;
            prdata[`PSP_STAT_ERR] <= err_reg;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= psp_pkg::st_idle;
      strobe_n <= 1'b1;
    end else begin
      case (state_reg)
        psp_pkg::st_idle: begin
          if (go_ok && direct_reg) begin
            strobe_n <= 1'b0; // R19
            state_reg <= psp_pkg::st_freeze;
          end else if (go_ok) begin
            state_reg <= psp_pkg::st_drive;
          end
        end
        psp_pkg::st_drive: begin
          if (tmr_expired) begin
            strobe_n <= 1'b0;
            state_reg <= psp_pkg::st_strb;
          end
        end
        psp_pkg::st_strb: begin
          if (tmr_expired) begin
            strobe_n <= 1'b1; // R16
            state_reg <= psp_pkg::st_idle;
          end
        end
        psp_pkg::st_freeze: begin
          if (tmr_expired) begin
            state_reg <= psp_pkg::st_change;
          end
        end
        psp_pkg::st_change: begin
          if (tmr_expired) begin
            strobe_n <= 1'b1; // R19
            state_reg <= psp_pkg::st_idle;
          end
        end
        default: begin
          strobe_n <= 1'b1;
          state_reg <= psp_pkg::st_idle;
        end
      endcase
    end
  end

  // ==========================================================
  // Port pins, deasserted (high) out of reset so the word reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mag_n <= '1;
      sign_n <= 1'b1;
      range_n <= 1'b1;
      standby_n <= 1'b1;
      extref_n <= 1'b1;
      irange_n <= 1'b1;
      ilim_n <= '1;
    end else if (load_pins) begin
      mag_n <= ~mag_out; // R01
      sign_n <= !sign;
      range_n <= !data_reg[`PSP_DATA_RANGE];
      standby_n <= !data_reg[`PSP_DATA_STANDBY];
      extref_n <= !data_reg[`PSP_DATA_EXTREF];
      irange_n <= !data_reg[`PSP_DATA_IRANGE];
      ilim_n <= ~data_reg[`PSP_DATA_ILIM_LSB +: `PSP_ILIM_W];
    end
  end

  // ==========================================================
  // Checks
  logic [`PSP_TMR_W-1:0] low_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= '0;
    end else if (strobe_n) begin
      low_cnt <= '0;
    end else if (low_cnt != '1) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  property p_hold_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(strobe_n) && !direct_reg |-> $past(low_cnt) >= `PSP_TMR_W'(`PSP_HOLD_CYC);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("strobe released before hold time"); // R16

  property p_hold_data;
    @(posedge pclk) disable iff (!presetn)
      !direct_reg && !strobe_n && $past(!strobe_n) |->
        $stable(mag_n) && $stable(sign_n) && $stable(range_n);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("data changed while strobe low"); // R16

  property p_direct_freeze;
    @(posedge pclk) disable iff (!presetn)
      direct_reg && ($changed(mag_n) || $changed(sign_n)) |-> !strobe_n && $past(!strobe_n);
  endproperty
  a_direct_freeze: assert property (p_direct_freeze) else $error("direct change outside strobe"); // R19

  property p_twos;
    @(posedge pclk) disable iff (!presetn)
      load_pins && !direct_reg && sign |=> (~mag_n) == $past(~mag + `PSP_MAG_ONE);
  endproperty
  a_twos: assert property (p_twos) else $error("negative word not two's complement"); // R12

  property p_no_signed_zero;
    @(posedge pclk) disable iff (!presetn)
      $fell(strobe_n) && !direct_reg && !sign_n |-> mag_n != '1;
  endproperty
  a_no_signed_zero: assert property (p_no_signed_zero) else $error("signed zero strobed"); // R12

  property p_reject;
    @(posedge pclk) disable iff (!presetn)
      go && !busy && bad_word |=> err_reg && state_reg == psp_pkg::st_idle && strobe_n;
  endproperty
  a_reject: assert property (p_reject) else $error("invalid word not rejected"); // R12

  property p_invert;
    @(posedge pclk) disable iff (!presetn)
      load_pins |=> mag_n == ~$past(mag_out) && standby_n == !$past(data_reg[`PSP_DATA_STANDBY]);
  endproperty
  a_invert: assert property (p_invert) else $error("pin sense not inverted"); // R01

  property p_setup;
    @(posedge pclk) disable iff (!presetn)
      load_pins && !direct_reg |=> strobe_n [*2];
  endproperty
  a_setup: assert property (p_setup) else $error("strobe fell without data setup"); // R16
endmodule

// *** sim/psp_dev_model.sv ***
/*
  Behavioural model of the programmable supply behind its parallel port.
  Assumes pins change only just after pclk edges; fault comes from the bench.
*/
`timescale 1ns/1ps
module psp_dev_model #(
  parameter int HOLD_CYC = 375,
  parameter int NRDY_CYC = 2500,
  parameter int STAB_CYC = 600
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic direct,
  input wire logic fault,
  input wire logic [22:0] pins_n,
  input wire logic strobe_n,
  output logic not_ready_n,
  output logic overload_n,
  output logic stab_err,
  output logic [22:0] applied,
  output int out_mv,
  output int lim_pct
);
  logic [22:0] pins;
  logic [22:0] word;
  logic strb, strb_d, flt;
  int hold_c, nrdy_c, stab_c;

  // ==========================================================
  // Decoding
  function automatic int volts(input logic [22:0] w, input logic dir);
    int m;
    m = w[13:0];
    if (w[14]) begin
      m = dir ? -m : m - 16384;
    end
    if (w[15]) begin
      m = m * 4;
    end
    return m;
  endfunction

  assign lim_pct = (applied[22:19] == 0) ? 10 :
    80 * applied[22] + 40 * applied[21] + 20 * applied[20] + 10 * applied[19];
  assign not_ready_n = (nrdy_c == 0);
  assign overload_n = !flt;

  // ==========================================================
  // Sampling; one flop so each strobe edge is seen once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
      strb <= 1'b0;
      strb_d <= 1'b0;
      flt <= 1'b0;
    end else begin
      pins <= ~pins_n;
      strb <= ~strobe_n;
      strb_d <= strb;
      flt <= fault;
    end
  end

  // ==========================================================
  // Output and flag timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied <= '0;
      out_mv <= 0;
      word <= '0;
      hold_c <= 0;
      nrdy_c <= 0;
      stab_c <= 0;
      stab_err <= 1'b0;
    end else begin
      hold_c <= (hold_c > 0) ? hold_c - 1 : 0;
      nrdy_c <= (nrdy_c > 0) ? nrdy_c - 1 : 0;
      stab_c <= (stab_c > 0) ? stab_c - 1 : 0;
      if (flt) begin
        nrdy_c <= NRDY_CYC;
      end
      if (!direct && strb && !strb_d) begin
        word <= pins;
        hold_c <= HOLD_CYC;
        nrdy_c <= NRDY_CYC;
        stab_c <= STAB_CYC;
      end
      if (!direct && hold_c == 1) begin
        applied <= word;
        out_mv <= volts(word, 1'b0);
      end
      if (direct && !strb) begin
        applied <= pins;
        out_mv <= volts(pins, 1'b1);
      end
      if (direct && !strb && strb_d) begin
        nrdy_c <= NRDY_CYC;
      end
      if (!direct && stab_c > 0 && pins !== word) begin
        stab_err <= 1'b1;
      end
      if (direct && !strb && strobe_n && pins !== ~pins_n) begin
        stab_err <= 1'b1;
      end
    end
  end
endmodule

// *** sim/tb.sv ***
/*
  Self-checking bench for psp_ctrl against the supply model.
  Assumes hw/ is on the include path.
*/
`timescale 1ns/1ps
`include "psp_regs.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [`PSP_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sign_n, range_n, standby_n, extref_n, irange_n, strobe_n;
  logic not_ready_n, overload_n, direct, fault, stab_err;
  logic [13:0] mag_n, mag;
  logic [3:0] ilim_n;
  logic [22:0] applied;
  int out_mv, lim_pct;
  int fails = 0, n_tests = 0, cyc = 0, prev = 0;
  localparam logic [22:0] tw [4] = '{23'h001000, 23'h00c001, 23'h006000, 23'h573fff};
  localparam logic [13:0] tm [4] = '{14'h1000, 14'h3fff, 14'h2000, 14'h3fff};
  localparam int to_mv [4] = '{4096, -4, -8192, 16383};
  localparam int tl [4] = '{10, 10, 10, 100};
  assign mag = ~mag_n;

  psp_ctrl psp_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mag_n(mag_n), .sign_n(sign_n), .range_n(range_n),
    .standby_n(standby_n), .extref_n(extref_n), .irange_n(irange_n), .ilim_n(ilim_n),
    .strobe_n(strobe_n), .not_ready_n(not_ready_n), .overload_n(overload_n));
  psp_dev_model psp_dev_model_i (.pclk(pclk), .presetn(presetn), .direct(direct),
    .fault(fault), .pins_n({ilim_n, irange_n, extref_n, standby_n, range_n, sign_n, mag_n}),
    .strobe_n(strobe_n), .not_ready_n(not_ready_n), .overload_n(overload_n),
    .stab_err(stab_err), .applied(applied), .out_mv(out_mv), .lim_pct(lim_pct));

  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [`PSP_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic test_done();
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  // ==========================================================
  // Tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    direct = 1'b0;
    fault = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk("idle mag", mag, 0);
    chk("idle ctl", {sign_n, range_n, standby_n, strobe_n}, 4'hf);
    chk("idle out", out_mv, 0);
    apb(1'b0, 12'hffc, '0);
    chk("bad slverr", serr, 1);
    chk("bad rdata", rd, 0);
    // Latched transfers, each held at the old level first
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `PSP_OFF_DATA, tw[i]);
      apb(1'b1, `PSP_OFF_CTRL, 32'h1);
      wait (strobe_n === 1'b0);
      chk("mag pins", mag, tm[i]);
      chk("held out", out_mv, prev);
      repeat (5) @(posedge pclk);
      chk("not ready", not_ready_n, 0);
      do apb(1'b0, `PSP_OFF_STAT, '0); while (rd[0] !== 1'b0);
      chk("stat nrdy", rd[1], 1);
      chk("applied", applied, {tw[i][22:14], tm[i]});
      chk("out", out_mv, to_mv[i]);
      chk("limit", lim_pct, tl[i]);
      prev = to_mv[i];
    end
    // Signed zero is never sent
    apb(1'b1, `PSP_OFF_DATA, 32'h00004000);
    apb(1'b1, `PSP_OFF_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    apb(1'b0, `PSP_OFF_STAT, '0);
    chk("err flag", rd[3], 1);
    chk("no strobe", strobe_n, 1);
    apb(1'b1, `PSP_OFF_STAT, 32'h8);
    apb(1'b0, `PSP_OFF_STAT, '0);
    chk("err clear", rd[3], 0);
    // Overload, then lingering not-ready
    fault <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `PSP_OFF_STAT, '0);
    chk("ovl set", rd[2:1], 3);
    fault <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, `PSP_OFF_STAT, '0);
    chk("ovl drop", rd[2:1], 1);
    wait (not_ready_n === 1'b1);
    repeat (4) @(posedge pclk);
    apb(1'b0, `PSP_OFF_STAT, '0);
    chk("ready", rd[2:1], 0);
    // Direct coupling, sign and magnitude as is
    direct <= 1'b1;
    apb(1'b1, `PSP_OFF_CTRL, 32'h2);
    apb(1'b1, `PSP_OFF_DATA, 32'h00004005);
    apb(1'b0, `PSP_OFF_CTRL, '0);
    chk("ctrl rd", rd, 32'h2);
    apb(1'b0, `PSP_OFF_DATA, '0);
    chk("data rd", rd, 32'h4005);
    apb(1'b1, `PSP_OFF_CTRL, 32'h3);
    wait (strobe_n === 1'b0);
    repeat (8) @(posedge pclk);
    chk("frozen", out_mv, prev);
    wait (strobe_n === 1'b1);
    repeat (4) @(posedge pclk);
    chk("direct mag", mag, 5);
    chk("direct sign", sign_n, 0);
    chk("direct out", out_mv, -5);
    chk("direct nrdy", not_ready_n, 0);
    chk("stable", stab_err, 0);
    test_done();
  end
endmodule
